/* File: pkg/ssp_pkg.sv */
// package for the dual synchronous serial port (spi side)
// assumes: axi4-lite register access, 50 MHz clock, two port instances
// Function
// RULE1 - slave-select synchronised slave only when slave mode field selects ss control
// RULE2 - slave select low enables shifting and drives serial data out
// RULE3 - slave select high floats serial data out at once, mid-byte too; code floats it after the 3-stage ss sync and the output register
// RULE4 - in ss-controlled slave mode, ss high holds the serial module reset
// RULE5 - software using edge select in slave mode must enable ss control
// RULE6 - serial module reset forces bit counter to zero (ss high or disable)
// RULE7 - data out configured as input never transmits; data in always input
// RULE8 - master mode in sleep freezes all clocks and transfer, resumes on run
// RULE9 - enabled interrupt wakes controller after master finishes; disabled, no wake
// RULE10 - slave shifts on external clock; after 8 bits sets irq flag, wakes
// RULE11 - device reset disables the port and aborts any transfer
// RULE12 - spi mode 00/01/10/11 map to polarity,edge 0,1 / 0,0 / 1,1 / 1,0
// RULE13 - two instances run independently at rates of their own mode fields
// RULE14 - both instances on shared timer base see timer changes equally
// RULE15 - full byte goes to transfer buffer, sets buffer-full and irq flags
// RULE16 - buffer write during shifting is ignored and sets write-collision flag
// RULE17 - slave shifts out and in on each external serial clock pulse
// RULE18 - deselect is synchronised before flags so partial bytes are discarded
package ssp_pkg;
   // byte addresses of the register words
   localparam logic [7:0] ADDR_P1_BUF   = 8'h00;
   localparam logic [7:0] ADDR_P1_CON1  = 8'h04;
   localparam logic [7:0] ADDR_P1_CON2  = 8'h08;
   localparam logic [7:0] ADDR_P1_STAT  = 8'h0C;
   localparam logic [7:0] ADDR_P2_BUF   = 8'h10;
   localparam logic [7:0] ADDR_P2_CON1  = 8'h14;
   localparam logic [7:0] ADDR_P2_CON2  = 8'h18;
   localparam logic [7:0] ADDR_P2_STAT  = 8'h1C;
   localparam logic [7:0] ADDR_OD_CFG   = 8'h20;
   localparam logic [7:0] ADDR_TMR_PER  = 8'h24;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
   localparam logic [7:0] ADDR_PWR      = 8'h30;
   // control one field positions
   localparam int CON1_WRITE_COLLISION_FLAG = 7;
   localparam int CON1_OV   = 6;
   localparam int CON1_EN   = 5;
   localparam int CON1_CKP  = 4;
   // status field positions
   localparam int STAT_SMP = 7;
   localparam int STAT_CKE = 6;
   localparam int STAT_BF  = 0;
   // mode field encodings
   localparam logic [3:0] MODE_M_DIV4  = 4'h0;
   localparam logic [3:0] MODE_M_DIV16 = 4'h1;
   localparam logic [3:0] MODE_M_DIV64 = 4'h2;
   localparam logic [3:0] MODE_M_TMR   = 4'h3;
   localparam logic [3:0] MODE_S_SS    = 4'h4;
   localparam logic [3:0] MODE_S_NOSS  = 4'h5;
   // master half-bit periods in system clocks (one instruction cycle = 4 clocks)
   localparam logic [5:0] HALF_DIV4  = 6'h02;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   localparam logic [7:0] TMR_PER_RST = 8'hFF;
   localparam logic [7:0] BITS_PER_BYTE = 8'h08;
   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic sck_i;
      logic sdi_i;
      logic ss_b_i;
   } ssp_pin_in_s;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
   } ssp_pin_out_s;
endpackage

/* File: rtl/ssp_dual_port.sv */
// two spi ports with an axi4-lite register slave and shared rate timer
// assumes: pins arrive asynchronous; open-drain resolved outside from enables
`timescale 1ns/10ps
module ssp_dual_port #(
   parameter int N_PORTS = 2
) (
   input  wire logic                  clock,         // system clock, 50 MHz
   input  wire logic                  rst_b,         // synchronous reset, active low
   input  wire logic                  clk_en,        // freezes all state while low; rst_b and engine mod_rst still act
   input  wire logic [7:0]            s_awaddr,      // write address
   input  wire logic                  s_awvalid,     // write address valid
   output logic                       s_awready,     // write address ready
   input  wire logic [31:0]           s_wdata,       // write data
   input  wire logic [3:0]            s_wstrb,       // write strobes
   input  wire logic                  s_wvalid,      // write data valid
   output logic                       s_wready,      // write data ready
   output logic [1:0]                 s_bresp,       // write response
   output logic                       s_bvalid,      // write response valid
   input  wire logic                  s_bready,      // write response ready
   input  wire logic [7:0]            s_araddr,      // read address
   input  wire logic                  s_arvalid,     // read address valid
   output logic                       s_arready,     // read address ready
   output logic [31:0]                s_rdata,       // read data
   output logic [1:0]                 s_rresp,       // read response
   output logic                       s_rvalid,      // read data valid
   input  wire logic                  s_rready,      // read data ready
   input  wire ssp_pkg::ssp_pin_in_s  pin_in  [N_PORTS], // per-port pin inputs
   output ssp_pkg::ssp_pin_out_s      pin_out [N_PORTS], // per-port pin drives
   input  wire logic                  sleep_req,     // core is in sleep
   output logic                       wake,          // wake request to core
   output logic                       irq            // level interrupt
);
   import ssp_pkg::*;

   if (N_PORTS != 2) begin : g_chk
      $error("ssp_dual_port serves exactly two ports");
   end

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] con1 [N_PORTS];
   logic [7:0] con2 [N_PORTS];
   logic [7:0] stat_cfg [N_PORTS];    // smp and cke
   logic [7:0] rx_buf [N_PORTS];
   logic       bf [N_PORTS];
   logic [7:0] od_cfg;
   logic [7:0] tmr_per;
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic [1:0] sdo_in_mode;           // data-out pin configured as input

   // bus handshakes
   logic       aw_hold;
   logic       w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       wr_fire;
   logic       rd_fire;
   logic [7:0] rd_addr_q;

   assign s_awready = !aw_hold && !s_bvalid;
   assign s_wready  = !w_hold && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign wr_fire   = clk_en && (aw_hold || (s_awvalid && s_awready))
                      && (w_hold || (s_wvalid && s_wready));
   assign rd_fire   = clk_en && s_arvalid && s_arready;

   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   assign wa = aw_hold ? aw_addr : s_awaddr;
   assign wd = w_hold ? w_data : s_wdata;
   assign ws = w_hold ? w_strb : s_wstrb;

   logic wbyte;
   assign wbyte = wr_fire && ws[0];

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            aw_hold  <= 1'b0;
            w_hold   <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= (wa > ADDR_PWR || wa[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
         end else begin
            if (s_awvalid && s_awready) begin
               aw_hold <= 1'b1;
               aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
               w_hold <= 1'b1;
               w_data <= s_wdata;
               w_strb <= s_wstrb;
            end
            if (s_bvalid && s_bready) s_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared rate timer: one tick every tmr_per+1 clocks, toggles half-bit
   logic [7:0] tmr_cnt;
   logic       tmr_tick;
   assign tmr_tick = (tmr_cnt == tmr_per);
   always_ff @(posedge clock) begin
      if (!rst_b) tmr_cnt <= 8'h00;
      else if (clk_en && !sleep_req) tmr_cnt <= tmr_tick ? 8'h00 : tmr_cnt + 8'h01; // RULE14
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-port engines
   logic [N_PORTS-1:0] byte_done;
   logic [N_PORTS-1:0] busy;
   logic [N_PORTS-1:0] buf_wr;
   logic [N_PORTS-1:0] buf_rd;
   logic [N_PORTS-1:0] write_collision_flag_set;
   logic [N_PORTS-1:0] ov_set;
   logic [7:0]         shreg_q [N_PORTS];

   genvar g;
   generate
      for (g = 0; g < N_PORTS; g++) begin : gp
         logic [2:0] sck_s, sdi_s, ss_s;
         logic       sck_d;
         logic [7:0] shreg;
         logic [3:0] bitcnt;
         logic [5:0] half_cnt;
         logic       sck_int;
         logic       en, master, ss_mode, slave, ss_hi, mod_rst, clock_idle_polarity, cke;
         logic       lead_edge, trail_edge, tick;
         logic [3:0] mode;
         logic       sdo_bit;

         always_ff @(posedge clock) begin
            if (!rst_b) begin
               sck_s <= 3'h0;
               sdi_s <= 3'h0;
               ss_s  <= 3'h7;
            end else if (clk_en) begin
               sck_s <= {sck_s[1:0], pin_in[g].sck_i};
               sdi_s <= {sdi_s[1:0], pin_in[g].sdi_i};
               ss_s  <= {ss_s[1:0], pin_in[g].ss_b_i};
            end
         end

         assign mode    = con1[g][3:0];
         assign en      = con1[g][CON1_EN];
         assign clock_idle_polarity     = con1[g][CON1_CKP];        // RULE12
         assign cke     = stat_cfg[g][STAT_CKE];    // RULE12
         assign master  = mode <= MODE_M_TMR;       // RULE13
         assign ss_mode = mode == MODE_S_SS;        // RULE1
         assign slave   = ss_mode || mode == MODE_S_NOSS;
         assign ss_hi   = ss_s[2];
         assign mod_rst = !en || (ss_mode && ss_hi); // RULE4 RULE18
         assign buf_wr[g] = wbyte && wa == (g == 0 ? ADDR_P1_BUF : ADDR_P2_BUF);
         assign buf_rd[g] = rd_fire && s_araddr == (g == 0 ? ADDR_P1_BUF : ADDR_P2_BUF);
         assign busy[g] = bitcnt != 4'h0 || (master && sck_int != clock_idle_polarity);

         // master bit clock
         always_comb begin
            tick = 1'b0;
            unique case (mode)
               MODE_M_DIV4:  tick = half_cnt == HALF_DIV4 - 6'h01;
               MODE_M_DIV16: tick = half_cnt == HALF_DIV16 - 6'h01;
               MODE_M_DIV64: tick = half_cnt == HALF_DIV64 - 6'h01;
               MODE_M_TMR:   tick = tmr_tick;    // RULE14
               default:      tick = 1'b0;
            endcase
         end

         // active sck edge in polarity-neutral form: lead = leaving idle
         logic sck_now;
         assign sck_now    = master ? sck_int : sck_s[2];
         assign lead_edge  = sck_now != sck_d && sck_now != clock_idle_polarity;
         assign trail_edge = sck_now != sck_d && sck_now == clock_idle_polarity;
         // cke=1: shift on trailing edge, sample on leading; cke=0 swapped
         logic shift_ev, sample_ev;
         assign sample_ev = cke ? lead_edge : trail_edge;   // RULE17
         assign shift_ev  = cke ? trail_edge : lead_edge;   // RULE17

         always_ff @(posedge clock) begin
            if (!rst_b || mod_rst) begin
               half_cnt <= 6'h00;
               sck_int  <= 1'b0;
               sck_d    <= 1'b0;
               bitcnt   <= 4'h0;                 // RULE6 RULE11
               if (!rst_b || buf_wr[g]) shreg <= rst_b ? wd[7:0] : 8'h00;
               if (!rst_b || buf_wr[g]) sdo_bit <= rst_b && wd[7];
               byte_done[g] <= 1'b0;
               if (rst_b) begin
                  sck_int <= clock_idle_polarity;
                  sck_d   <= master ? clock_idle_polarity : sck_s[2];
               end
            end else if (clk_en && !(master && sleep_req)) begin   // RULE8
               byte_done[g] <= 1'b0;
               sck_d <= sck_now;
               if (master && (bitcnt != 4'h0 || sck_int != clock_idle_polarity)) begin
                  half_cnt <= tick ? 6'h00 : half_cnt + 6'h01;
                  if (tick) sck_int <= !sck_int;
               end else begin
                  half_cnt <= 6'h00;
                  sck_int  <= clock_idle_polarity;
               end
               if (buf_wr[g] && !busy[g]) begin
                  shreg   <= wd[7:0];
                  sdo_bit <= wd[7];
                  if (master) bitcnt <= BITS_PER_BYTE[3:0];
               end else if (sample_ev && (master ? bitcnt != 4'h0 : 1'b1)) begin
                  shreg <= {shreg[6:0], sdi_s[2]};          // RULE10
                  if (master) begin
                     bitcnt <= bitcnt - 4'h1;
                     byte_done[g] <= bitcnt == 4'h1;
                  end else begin
                     bitcnt <= (bitcnt == 4'h7) ? 4'h0 : bitcnt + 4'h1;
                     byte_done[g] <= bitcnt == 4'h7;        // RULE10
                  end
               end else if (shift_ev) begin
                  sdo_bit <= shreg[7];
               end
            end
         end
         assign shreg_q[g] = shreg;

         assign write_collision_flag_set[g] = buf_wr[g] && busy[g];                 // RULE16
         assign ov_set[g]   = byte_done[g] && bf[g];

         always_ff @(posedge clock) begin
            if (!rst_b) begin
               pin_out[g] <= '0;
            end else if (clk_en) begin
               pin_out[g].sck_o  <= od_cfg[g] ? 1'b0 : sck_int;
               pin_out[g].sck_oe <= en && master && (od_cfg[g] ? !sck_int : 1'b1);
               pin_out[g].sdo_o  <= od_cfg[g] ? 1'b0 : sdo_bit;
               // RULE2 RULE3 RULE7
               pin_out[g].sdo_oe <= en && !sdo_in_mode[g] && !(ss_mode && ss_hi)
                                    && (master || slave)
                                    && (od_cfg[g] ? !sdo_bit : 1'b1);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // register writes and hardware flags
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         for (int i = 0; i < N_PORTS; i++) begin
            con1[i]     <= 8'h00;                    // RULE11
            con2[i]     <= 8'h00;
            stat_cfg[i] <= 8'h00;
            rx_buf[i]   <= 8'h00;
            bf[i]       <= 1'b0;
         end
         od_cfg      <= 8'h00;
         tmr_per     <= TMR_PER_RST;
         sdo_in_mode <= 2'h0;
      end else if (clk_en) begin
         for (int i = 0; i < N_PORTS; i++) begin
            if (wbyte && wa == (i == 0 ? ADDR_P1_CON1 : ADDR_P2_CON1)) con1[i] <= wd[7:0];
            if (wbyte && wa == (i == 0 ? ADDR_P1_CON2 : ADDR_P2_CON2)) con2[i] <= wd[7:0];
            if (wbyte && wa == (i == 0 ? ADDR_P1_STAT : ADDR_P2_STAT))
               stat_cfg[i] <= {wd[7:6], 6'h00};
            if (write_collision_flag_set[i]) con1[i][CON1_WRITE_COLLISION_FLAG] <= 1'b1;     // RULE16
            if (ov_set[i]) con1[i][CON1_OV] <= 1'b1;
            if (buf_rd[i]) bf[i] <= 1'b0;
            if (!con1[i][CON1_EN]) bf[i] <= 1'b0;
            if (byte_done[i]) begin
               rx_buf[i] <= shreg_q[i];                       // RULE15
               bf[i]     <= 1'b1;                             // RULE15
            end
         end
         if (wbyte && wa == ADDR_OD_CFG) od_cfg <= wd[7:0];
         if (wbyte && wa == ADDR_TMR_PER) tmr_per <= wd[7:0];
         if (wbyte && wa == ADDR_PWR) sdo_in_mode <= wd[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: bit0/1 byte done, bit2/3 write collision; read clears, set wins
   logic [7:0] irq_ev;
   assign irq_ev = {4'h0, write_collision_flag_set, byte_done};
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq_stat <= 8'h00;
         irq_mask <= 8'h00;
      end else if (clk_en) begin
         irq_stat <= ((rd_fire && s_araddr == ADDR_IRQ_STAT) ? 8'h00 : irq_stat) | irq_ev;
         if (wbyte && wa == ADDR_IRQ_MASK) irq_mask <= wd[7:0];
      end
   end
   assign irq  = |(irq_stat & irq_mask);
   assign wake = irq;                                         // RULE9

   ////////////////////////////////////////////////////////////////////////////
   // read channel
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= RESP_OKAY;
         rd_addr_q <= 8'h00;
      end else if (clk_en) begin
         if (rd_fire) begin
            s_rvalid  <= 1'b1;
            rd_addr_q <= s_araddr;
            s_rresp   <= RESP_OKAY;
            unique case (s_araddr)
               ADDR_P1_BUF:   s_rdata <= {24'h0, rx_buf[0]};
               ADDR_P1_CON1:  s_rdata <= {24'h0, con1[0]};
               ADDR_P1_CON2:  s_rdata <= {24'h0, con2[0]};
               ADDR_P1_STAT:  s_rdata <= {24'h0, stat_cfg[0][7:6], 5'h00, bf[0]};
               ADDR_P2_BUF:   s_rdata <= {24'h0, rx_buf[1]};
               ADDR_P2_CON1:  s_rdata <= {24'h0, con1[1]};
               ADDR_P2_CON2:  s_rdata <= {24'h0, con2[1]};
               ADDR_P2_STAT:  s_rdata <= {24'h0, stat_cfg[1][7:6], 5'h00, bf[1]};
               ADDR_OD_CFG:   s_rdata <= {24'h0, od_cfg};
               ADDR_TMR_PER:  s_rdata <= {24'h0, tmr_per};
               ADDR_IRQ_STAT: s_rdata <= {24'h0, irq_stat};
               ADDR_IRQ_MASK: s_rdata <= {24'h0, irq_mask};
               ADDR_PWR:      s_rdata <= {30'h0, sdo_in_mode};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* File: testbench/ssp_dual_port_checker.sv */
// assertions on the dual serial port top-level ports
// assumes: bound into ssp_dual_port; port 1 mode is seen on its axi writes
`timescale 1ns/10ps
module ssp_dual_port_checker #(
   parameter int N_PORTS = 2
) (
   input wire logic                  clock,             // system clock
   input wire logic                  rst_b,             // sync reset, active low
   input wire logic [7:0]            s_awaddr,          // write address
   input wire logic                  s_awvalid,         // write address valid
   input wire logic                  s_awready,         // write address ready
   input wire logic [31:0]           s_wdata,           // write data
   input wire logic                  s_wvalid,          // write data valid
   input wire logic                  s_wready,          // write data ready
   input wire logic                  s_bvalid,          // write response valid
   input wire logic                  s_bready,          // write response ready
   input wire logic                  s_arvalid,         // read address valid
   input wire logic                  s_arready,         // read address ready
   input wire logic                  s_rvalid,          // read data valid
   input wire ssp_pkg::ssp_pin_in_s  pin_in [N_PORTS],  // pin inputs
   input wire ssp_pkg::ssp_pin_out_s pin_out [N_PORTS], // pin drives
   input wire logic                  sleep_req,         // core sleep
   input wire logic                  wake,              // wake request
   input wire logic                  irq                // level interrupt
);
   import ssp_pkg::*;
   logic ss_mode; // port 1 enabled as slave with select control

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   always_ff @(posedge clock) begin
      if (!rst_b)
         ss_mode <= 1'b0;
      else if (s_awvalid && s_awready && s_wvalid && s_wready && s_awaddr == ADDR_P1_CON1)
         ss_mode <= s_wdata[CON1_EN] && s_wdata[3:0] == MODE_S_SS;
   end

   ////////////////////////////////////////////////////////////////////////////
   wake_follows_a: assert property (wake == irq)
      else $error("wake differs from irq");
   reset_quiet_a: assert property ($rose(rst_b) |->
      !irq && !pin_out[0].sdo_oe && !pin_out[0].sck_oe && !pin_out[1].sck_oe)
      else $error("outputs active right after reset");
   ss_float_a: assert property ((ss_mode && pin_in[0].ss_b_i) [*8]
      |-> !pin_out[0].sdo_oe) else $error("data out driven while deselected");
   sleep_freeze_a: assert property (sleep_req [*3] ##0 pin_out[0].sck_oe
      |-> $stable(pin_out[0].sck_o)) else $error("master clock moved in sleep");
   wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
      |=> s_bvalid) else $error("write response late");
   b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
      else $error("write response dropped");
   rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
      else $error("read answer late");
   busy_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready)
      else $error("write taken while response pending");

   cover property (ss_mode && $fell(pin_in[0].ss_b_i));
   cover property ($rose(irq));
   cover property (sleep_req && pin_out[0].sck_oe);
endmodule

bind ssp_dual_port ssp_dual_port_checker #(.N_PORTS(N_PORTS)) i_chk (
   .clock(clock), .rst_b(rst_b), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
   .s_awready(s_awready), .s_wdata(s_wdata), .s_wvalid(s_wvalid), .s_wready(s_wready),
   .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rvalid(s_rvalid), .pin_in(pin_in), .pin_out(pin_out),
   .sleep_req(sleep_req), .wake(wake), .irq(irq));

/* File: testbench/ssp_spi_master_model.sv */
// spi master model driving port 1 pins as the far-side controller
// assumes: 160 ns serial clock, one frame at a time called from the bench
`timescale 1ns/10ps
module ssp_spi_master_model (
   output logic      ss_b,   // slave select, active low
   output logic      sck,    // serial clock, idles at ckp between frames
   output logic      sdi,    // data into the port
   input  wire logic sdo,    // data out of the port
   input  wire logic sdo_oe, // port drives sdo
   input  wire logic clock_idle_polarity,    // idle clock level
   input  wire logic cke     // 1: port samples on the leading edge
);
   logic [7:0] rx;
   wire        sdo_w = sdo_oe ? sdo : 1'bz;

   initial ss_b = 1'b1;
   initial sdi = 1'b0;
   always @* if (ss_b) sck = clock_idle_polarity;

   // samples late in each half so the port's input sync lag is absorbed
   task automatic frame(input logic [7:0] tx, input int n);
      ss_b = 1'b0;
      if (cke) sdi = tx[7];
      #160;
      for (int i = 0; i < n; i++) begin
         sck = ~clock_idle_polarity;
         if (!cke) sdi = tx[7];
         #79;
         if (cke) rx = {rx[6:0], sdo_w};
         #1;
         sck = clock_idle_polarity;
         tx = tx << 1;
         if (cke) sdi = tx[7];
         #79;
         if (!cke) rx = {rx[6:0], sdo_w};
         #1;
      end
      #320;
      ss_b = 1'b1;
      // released line must not keep its last level
      sdi = ~sdi;
   endtask
endmodule

/* File: testbench/tb_ssp_dual_port.sv */
// self-checking bench: axi register calls and spi frames on port 1
// assumes: master model on port 1 pins, port 2 pins held idle here
`timescale 1ns/10ps
module tb_ssp_dual_port;
   import ssp_pkg::*;
   logic        clock, wake, irq, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic        rst_b = 1'b0, clk_en = 1'b1, sleep_req = 1'b0, clock_idle_polarity = 1'b0, cke = 1'b0;
   logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic        s_arvalid = 1'b0, s_rready = 1'b0, m_ss_b, m_sck, m_sdi;
   logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata, rd_val;
   logic [3:0]  s_wstrb = 4'hF;
   logic [1:0]  s_bresp, s_rresp, resp;
   ssp_pin_in_s  pin_in [2];
   ssp_pin_out_s pin_out [2];
   ssp_pin_in_s  p2_in = 3'b001;
   int          bad_count = 0, comparisons = 0;

   assign pin_in[0] = {m_sck, m_sdi, m_ss_b};
   assign pin_in[1] = p2_in;

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   ssp_dual_port i_ssp_dual_port (
      .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .pin_in(pin_in), .pin_out(pin_out), .sleep_req(sleep_req),
      .wake(wake), .irq(irq));

   ssp_spi_master_model i_master (
      .ss_b(m_ss_b), .sck(m_sck), .sdi(m_sdi), .sdo(pin_out[0].sdo_o),
      .sdo_oe(pin_out[0].sdo_oe), .clock_idle_polarity(clock_idle_polarity), .cke(cke));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      rd_val = s_rdata;
      resp = s_rresp;
      s_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_val, e);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask

   // one frame from the master, optionally colliding with a buffer write
   task automatic xfer(input logic [7:0] tx, input int n, input logic col, input logic oe);
      fork
         i_master.frame(tx, n);
         begin
            #305;
            chk({31'h0, pin_out[0].sdo_oe}, {31'h0, oe});
            if (col) wr(ADDR_P1_BUF, 32'h11);
         end
      join
      repeat (10) @(posedge clock);
      chk({31'h0, pin_out[0].sdo_oe}, 32'h0);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #300000;
      bad_count++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      rchk(ADDR_P1_CON1, 32'h0);
      rchk(ADDR_TMR_PER, {24'h0, TMR_PER_RST});
      rd(8'h3C);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(ADDR_IRQ_MASK, 32'h1);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_P1_CON1, 32'h0);
         clock_idle_polarity = m[1];
         cke = !m[0];
         wr(ADDR_P1_STAT, {25'h0, cke, 6'h0});
         wr(ADDR_P1_CON1, {26'h0, 1'b1, clock_idle_polarity, MODE_S_SS});
         wr(ADDR_P1_BUF, {24'h0, 8'hA5 ^ 8'(m)});
         xfer(8'h3C + 8'(m), 8, 1'b0, 1'b1);
         chk({24'h0, i_master.rx}, {24'h0, 8'hA5 ^ 8'(m)});
         chk({31'h0, wake}, 32'h1);
         rchk(ADDR_P1_STAT, {25'h0, cke, 5'h0, 1'b1});
         rchk(ADDR_P1_BUF, {24'h0, 8'h3C + 8'(m)});
         rchk(ADDR_IRQ_STAT, 32'h1);
         chk({31'h0, irq}, 32'h0);
      end
      xfer(8'hFF, 4, 1'b1, 1'b1);
      rchk(ADDR_P1_CON1, 32'hB4);
      rchk(ADDR_IRQ_STAT, 32'h4);
      rchk(ADDR_P1_STAT, 32'h0);
      wr(ADDR_P1_CON1, 32'h34);
      xfer(8'h5A, 8, 1'b0, 1'b1);
      rchk(ADDR_P1_BUF, 32'h5A);
      wr(ADDR_PWR, 32'h1);
      xfer(8'hC3, 8, 1'b0, 1'b0);
      rchk(ADDR_P1_BUF, 32'hC3);
      wr(ADDR_PWR, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_P1_CON1, 32'h0);
      wr(ADDR_TMR_PER, 32'h10);
      wr(ADDR_P1_CON1, {26'h0, 2'b10, MODE_M_DIV64});
      wr(ADDR_P2_CON1, {26'h0, 2'b10, MODE_M_TMR});
      rd(ADDR_IRQ_STAT);
      wr(ADDR_P1_BUF, 32'h96);
      wr(ADDR_P2_BUF, 32'h69);
      repeat (50) @(posedge clock);
      sleep_req <= 1'b1;
      repeat (2000) @(posedge clock);
      rchk(ADDR_IRQ_STAT, 32'h0);
      sleep_req <= 1'b0;
      repeat (2000) @(posedge clock);
      chk({31'h0, wake}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h3);
      chk({31'h0, wake}, 32'h1);
      rchk(ADDR_IRQ_STAT, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wrap_up();
   end
endmodule
